// File: core/cma_core.sv
// CPU addressing core: program counter, stack, banked data memory.
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ns
module cma_core (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire cma_pkg::cma_cmd_t cmd_i,
  input wire cma_pkg::cma_flags_t flags_i,
  input wire logic wdt_timeout_i,
  input wire logic sleep_i,
  input wire logic clrwdt_i,
  output logic [14:0] pc_o,
  output logic [14:0] pm_addr_o,
  input wire logic [13:0] pm_data_i,
  output logic soft_reset_o
);
  // ********************************************************
  // Helpers
  // ********************************************************
  // Keeps any program address inside the implemented words.
  function automatic logic [14:0] pm_wrap(input logic [14:0] a);
    return a & cma_pkg::PM_WRAP_MASK;
  endfunction

  // Maps a 12-bit data address onto a storage location.
  function automatic cma_pkg::cma_loc_t res_data(input logic [11:0] a);
    cma_pkg::cma_loc_t l;
    logic [4:0] b;
    logic [6:0] o;
    b = a[11:7];
    o = a[6:0];
    l.kind = cma_pkg::LOC_NONE;
    l.idx = '0;
    // The core block ignores the bank entirely.
    if (o <= cma_pkg::CORE_LAST) begin
      l.kind = cma_pkg::LOC_CORE;
      l.idx = {11'h000, o[3:0]};
    end else if (a == cma_pkg::PCON_ADDR) begin
      // Only one SFR lives here; the rest of the SFR span reads zero.
      l.kind = cma_pkg::LOC_PCON;
    end else if (o >= cma_pkg::COMMON_FIRST) begin
      l.kind = cma_pkg::LOC_COMMON;
      l.idx = {11'h000, o[3:0]};
    end else if (o >= cma_pkg::GPR_FIRST && b < cma_pkg::GPR_BANKS) begin
      l.kind = cma_pkg::LOC_GPR;
      l.idx = 15'(b) * 15'(cma_pkg::GPR_BYTES) +
              15'(o - cma_pkg::GPR_FIRST);
    end
    return l;
  endfunction

  // Maps a pointer value onto the unified pointer space.
  function automatic cma_pkg::cma_loc_t res_ptr(input logic [15:0] f);
    cma_pkg::cma_loc_t l;
    logic [15:0] lin;
    lin = f - cma_pkg::PTR_LIN_BASE;
    l.kind = cma_pkg::LOC_NONE;
    l.idx = '0;
    if (f[cma_pkg::PTR_PM_BIT]) begin
      l.kind = cma_pkg::LOC_PM;
      l.idx = pm_wrap(f[14:0]);
    end else if (f < cma_pkg::PTR_DATA_END) begin
      l = res_data(f[11:0]);
    end else if (f >= cma_pkg::PTR_LIN_BASE &&
                 lin < cma_pkg::GPR_LIN_SIZE) begin
      // Linear view: consecutive GPR bytes across banks.
      l.kind = cma_pkg::LOC_GPR;
      l.idx = lin[14:0];
    end
    return l;
  endfunction

  // Reads a core register; the indirect ports themselves read zero.
  function automatic logic [7:0] core_rd(input cma_pkg::cma_state_t s,
                                         input logic [3:0] i);
    logic [7:0] r;
    r = 8'h00;
    case (i)
      cma_pkg::IDX_PC_LO: r = s.pc[7:0];
      cma_pkg::IDX_STATUS: r = {3'h0, s.status};
      cma_pkg::IDX_P0_LO: r = s.ptr0[7:0];
      cma_pkg::IDX_P0_HI: r = s.ptr0[15:8];
      cma_pkg::IDX_P1_LO: r = s.ptr1[7:0];
      cma_pkg::IDX_P1_HI: r = s.ptr1[15:8];
      cma_pkg::IDX_BANK: r = {3'h0, s.bank};
      cma_pkg::IDX_ACC: r = s.acc;
      cma_pkg::IDX_PC_HI: r = {1'b0, s.pc_hi};
      cma_pkg::IDX_IRQC: r = s.irqc;
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // ********************************************************
  // Storage and decode
  // ********************************************************
  cma_pkg::cma_state_t st_reg;
  cma_pkg::cma_state_t st_next;
  cma_pkg::cma_loc_t bus_loc;
  logic [7:0] gpr_mem [1040];
  logic [7:0] com_mem [16];
  logic req_new;
  logic req_pm;
  logic wr_en;
  logic mem_we;
  logic [7:0] rd_byte;
  logic push;
  logic pop;

  // Resolves the bus address; the indirect ports go through a pointer.
  always_comb begin
    logic [13:0] wi;
    logic [11:0] daddr;
    wi = wb_adr_i[15:2];
    daddr = wi[11:0];
    bus_loc.kind = cma_pkg::LOC_NONE;
    bus_loc.idx = '0;
    if (!wi[cma_pkg::WB_HIGH_BIT]) begin
      // Direct window takes the bank from the selector.
      if (wi[cma_pkg::WB_DIRECT_BIT]) begin
        daddr = {st_reg.bank, wi[6:0]};
      end
      bus_loc = res_data(daddr);
    end
    if (bus_loc.kind == cma_pkg::LOC_CORE && bus_loc.idx[3:1] == 3'h0) begin
      bus_loc = res_ptr(bus_loc.idx[0] ? st_reg.ptr1 : st_reg.ptr0);
      // A pointer aimed at an indirect port reads nothing.
      if (bus_loc.kind == cma_pkg::LOC_CORE &&
          bus_loc.idx[3:1] == 3'h0) begin
        bus_loc.kind = cma_pkg::LOC_NONE;
      end
    end
    req_new = wb_cyc_i && wb_stb_i && st_reg.bus == cma_pkg::BUS_IDLE;
    req_pm = bus_loc.kind == cma_pkg::LOC_PM;
    wr_en = req_new && wb_we_i && wb_sel_i[0];
    mem_we = wr_en && (bus_loc.kind == cma_pkg::LOC_GPR ||
                       bus_loc.kind == cma_pkg::LOC_COMMON);
    case (bus_loc.kind)
      cma_pkg::LOC_CORE: rd_byte = core_rd(st_reg, bus_loc.idx[3:0]);
      cma_pkg::LOC_PCON: rd_byte = {st_reg.ovf, st_reg.unf, 5'h00,
                                    st_reg.rsten};
      cma_pkg::LOC_GPR: rd_byte = gpr_mem[bus_loc.idx[10:0]];
      cma_pkg::LOC_COMMON: rd_byte = com_mem[bus_loc.idx[3:0]];
      default: rd_byte = 8'h00;
    endcase
  end

  // RAM bytes are kept outside the state record; writes land here.
  always_ff @(posedge clk_i) begin
    if (mem_we && bus_loc.kind == cma_pkg::LOC_GPR) begin
      gpr_mem[bus_loc.idx[10:0]] <= wb_dat_i[7:0];
    end
    if (mem_we && bus_loc.kind == cma_pkg::LOC_COMMON) begin
      com_mem[bus_loc.idx[3:0]] <= wb_dat_i[7:0];
    end
  end

  // ********************************************************
  // Next state
  // ********************************************************
  // Bus first, then sequencer, then hardware flags, so hardware wins.
  always_comb begin
    logic [7:0] d;
    d = wb_dat_i[7:0];
    st_next = st_reg;
    st_next.soft_rst = 1'b0;
    push = cmd_i.op == cma_pkg::OP_CALL || cmd_i.op == cma_pkg::OP_IRQ;
    pop = cmd_i.op == cma_pkg::OP_RET || cmd_i.op == cma_pkg::OP_RETFIE;
    case (st_reg.bus)
      cma_pkg::BUS_IDLE: begin
        if (req_new && req_pm && !wb_we_i) begin
          // The word is fetched first, costing one cycle.
          st_next.pm_addr = bus_loc.idx;
          st_next.bus = cma_pkg::BUS_PMWAIT;
        end else if (req_new) begin
          // Writes to program memory are simply dropped.
          st_next.ack = 1'b1;
          st_next.bus = cma_pkg::BUS_ACK;
          st_next.dat = rd_byte;
        end
      end
      cma_pkg::BUS_PMWAIT: begin
        st_next.dat = pm_data_i[7:0];
        st_next.ack = 1'b1;
        st_next.bus = cma_pkg::BUS_ACK;
      end
      cma_pkg::BUS_ACK: begin
        st_next.ack = 1'b0;
        st_next.bus = cma_pkg::BUS_IDLE;
      end
      default: begin
        st_next.ack = 1'b0;
        st_next.bus = cma_pkg::BUS_IDLE;
      end
    endcase
    if (wr_en && bus_loc.kind == cma_pkg::LOC_PCON) begin
      st_next.ovf = d[cma_pkg::PCON_OVF];
      st_next.unf = d[cma_pkg::PCON_UNF];
      st_next.rsten = d[cma_pkg::PCON_RSTEN];
    end
    if (wr_en && bus_loc.kind == cma_pkg::LOC_CORE) begin
      case (bus_loc.idx[3:0])
        cma_pkg::IDX_PC_LO: st_next.pc = pm_wrap({st_reg.pc_hi, d});
        // Only the ALU flags are writable here.
        cma_pkg::IDX_STATUS: st_next.status[2:0] = d[2:0];
        cma_pkg::IDX_P0_LO: st_next.ptr0[7:0] = d;
        cma_pkg::IDX_P0_HI: st_next.ptr0[15:8] = d;
        cma_pkg::IDX_P1_LO: st_next.ptr1[7:0] = d;
        cma_pkg::IDX_P1_HI: st_next.ptr1[15:8] = d;
        cma_pkg::IDX_BANK: st_next.bank = d[4:0];
        cma_pkg::IDX_ACC: st_next.acc = d;
        cma_pkg::IDX_PC_HI: st_next.pc_hi = d[6:0];
        cma_pkg::IDX_IRQC: st_next.irqc = d;
        default: st_next.acc = st_next.acc;
      endcase
    end
    // Sequencer commands; a jump here beats a same-cycle pc byte write.
    case (cmd_i.op)
      cma_pkg::OP_STEP: st_next.pc = pm_wrap(st_reg.pc + 15'h0001);
      cma_pkg::OP_GOTO: st_next.pc = pm_wrap(cmd_i.target);
      default: st_next.pc = st_next.pc;
    endcase
    if (push) begin
      if (st_reg.sp == cma_pkg::STK_FULL) begin
        st_next.ovf = 1'b1;
        st_next.soft_rst = st_reg.rsten;
      end else begin
        // Calls save the next word, interrupts the current one.
        st_next.stk[st_reg.sp[3:0]] = (cmd_i.op == cma_pkg::OP_CALL) ?
          pm_wrap(st_reg.pc + 15'h0001) : st_reg.pc;
        st_next.sp = st_reg.sp + 5'h01;
      end
      st_next.pc = (cmd_i.op == cma_pkg::OP_CALL) ?
        pm_wrap(cmd_i.target) : cma_pkg::IRQ_VEC;
    end
    if (cmd_i.op == cma_pkg::OP_IRQ) begin
      st_next.sh_status = st_reg.status[2:0];
      st_next.sh_acc = st_reg.acc;
      st_next.sh_bank = st_reg.bank;
      st_next.sh_pc_hi = st_reg.pc_hi;
      st_next.sh_ptr0 = st_reg.ptr0;
      st_next.sh_ptr1 = st_reg.ptr1;
    end
    if (pop) begin
      if (st_reg.sp == 5'h00) begin
        st_next.unf = 1'b1;
        st_next.soft_rst = st_reg.rsten;
      end else begin
        st_next.pc = st_reg.stk[4'(st_reg.sp - 5'h01)];
        st_next.sp = st_reg.sp - 5'h01;
      end
    end
    if (cmd_i.op == cma_pkg::OP_RETFIE) begin
      st_next.status[2:0] = st_reg.sh_status;
      st_next.acc = st_reg.sh_acc;
      st_next.bank = st_reg.sh_bank;
      st_next.pc_hi = st_reg.sh_pc_hi;
      st_next.ptr0 = st_reg.sh_ptr0;
      st_next.ptr1 = st_reg.sh_ptr1;
    end
    // Soft reset restarts fetch but keeps the flags that explain it.
    if (st_next.soft_rst) begin
      st_next.pc = cma_pkg::RESET_VEC;
      st_next.sp = 5'h00;
    end
    if (wdt_timeout_i) begin
      st_next.status[cma_pkg::ST_WDT] = 1'b0;
    end
    if (sleep_i) begin
      st_next.status[cma_pkg::ST_SLP] = 1'b0;
      st_next.status[cma_pkg::ST_WDT] = 1'b1;
    end
    if (clrwdt_i) begin
      st_next.status[cma_pkg::ST_SLP] = 1'b1;
      st_next.status[cma_pkg::ST_WDT] = 1'b1;
    end
    // ALU results beat a bus write to the same flags.
    if (flags_i.valid) begin
      st_next.status[cma_pkg::ST_Z] = flags_i.z;
      st_next.status[cma_pkg::ST_HC] = flags_i.hc;
      st_next.status[cma_pkg::ST_C] = flags_i.c;
    end
  end

  // Single state register; pointers reset to zero, RAM bytes are not reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.pc <= cma_pkg::RESET_VEC;
      st_reg.status <= cma_pkg::STATUS_RST;
      st_reg.rsten <= cma_pkg::PCON_RSTEN_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_dat_o = {24'h00_0000, st_reg.dat};
  assign wb_ack_o = st_reg.ack;
  assign pc_o = st_reg.pc;
  assign pm_addr_o = st_reg.pm_addr;
  assign soft_reset_o = st_reg.soft_rst;

  // ********************************************************
  // Assertions
  // ********************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_pm_req;
    req_new && req_pm && !wb_we_i;
  endsequence
  sequence s_pm_ans;
    !wb_ack_o ##1 (wb_ack_o && wb_dat_o[7:0] == $past(pm_data_i[7:0]));
  endsequence
  sequence s_call_ret;
    (cmd_i.op == cma_pkg::OP_CALL && st_reg.sp < cma_pkg::STK_FULL)
    ##1 (cmd_i.op == cma_pkg::OP_RET);
  endsequence

  property p_pc_wrap;
    pc_o[14:13] == 2'h0 && pm_addr_o[14:13] == 2'h0;
  endproperty
  a_pc_wrap: assert property (p_pc_wrap)
    else $error("program address beyond implemented words");

  property p_reset_vec;
    disable iff (1'b0) rst_i |=> (pc_o == 15'h0000 && !wb_ack_o);
  endproperty
  a_reset_vec: assert property (p_reset_vec)
    else $error("pc not at reset vector after reset");

  property p_irq_vec;
    cmd_i.op == cma_pkg::OP_IRQ && st_reg.sp < cma_pkg::STK_FULL
    |=> pc_o == 15'h0004;
  endproperty
  a_irq_vec: assert property (p_irq_vec)
    else $error("interrupt did not vector to 0004h");

  property p_pm_extra;
    s_pm_req |=> s_pm_ans;
  endproperty
  a_pm_extra: assert property (p_pm_extra)
    else $error("program read via pointer not one cycle late");

  property p_ovf;
    push && st_reg.sp == cma_pkg::STK_FULL
    |=> st_reg.ovf && soft_reset_o == $past(st_reg.rsten)
        && (!soft_reset_o || pc_o == 15'h0000);
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("stack overflow not flagged");

  property p_unf;
    pop && st_reg.sp == 5'h00 |=> st_reg.unf && $stable(st_reg.sp);
  endproperty
  a_unf: assert property (p_unf)
    else $error("stack underflow not flagged");

  property p_to_pd;
    !wdt_timeout_i && !sleep_i && !clrwdt_i
    |=> $stable(st_reg.status[4:3]);
  endproperty
  a_to_pd: assert property (p_to_pd)
    else $error("timeout or sleep flag changed without cause");

  property p_flags_win;
    flags_i.valid |=> st_reg.status[2:0] ==
      $past({flags_i.z, flags_i.hc, flags_i.c});
  endproperty
  a_flags_win: assert property (p_flags_win)
    else $error("ALU flags lost to a status write");

  property p_sp_bound;
    st_reg.sp <= cma_pkg::STK_FULL;
  endproperty
  a_sp_bound: assert property (p_sp_bound)
    else $error("stack pointer beyond sixteen entries");

  property p_ret;
    s_call_ret |=> pc_o == pm_wrap($past(pc_o, 2) + 15'h0001);
  endproperty
  a_ret: assert property (p_ret)
    else $error("return did not restore the call site");

  property p_pm_nowrite;
    req_new && req_pm && wb_we_i |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_pm_nowrite: assert property (p_pm_nowrite)
    else $error("program write not acknowledged as no-op");
endmodule

// File: include/cma_pkg.sv
// Constants and types shared by the CPU addressing core.
// Contract
// - return stack holds sixteen 15-bit entries
// - stack misuse sets flag, optional soft reset
// - two 16-bit pointers reach all memories
// - indirect program reads take one extra cycle
// - 15-bit program counter, 32K word space
// - program addresses wrap into 8192 words
// - reset starts at 0000h, interrupt at 0004h
// - pointer bit 15 reads program word low byte
// - indirect writes never touch program memory
// - 32 banks of 128 bytes each
// - 12-bit data address, bank plus offset
// - direct accesses use the bank selector
// - unimplemented data locations read zero
// - core registers appear in every bank
// - ALU flag results override status writes
// - timeout and sleep flags ignore software
// - interrupt saves and restores shadow copies
// - pointers give linear view of RAM
// - common RAM shared across all banks
// - SFRs follow core registers in banks
package cma_pkg;
  // ********************************************************
  // Program side
  // ********************************************************
  localparam logic [4:0] STK_FULL = 5'h10;
  localparam logic [14:0] PM_WRAP_MASK = 15'h1fff;
  localparam logic [14:0] RESET_VEC = 15'h0000;
  localparam logic [14:0] IRQ_VEC = 15'h0004;
  // ********************************************************
  // Data side
  // ********************************************************
  localparam logic [6:0] CORE_LAST = 7'h0b;
  localparam logic [6:0] GPR_FIRST = 7'h20;
  localparam logic [6:0] COMMON_FIRST = 7'h70;
  localparam logic [6:0] GPR_BYTES = 7'h50;
  localparam logic [4:0] GPR_BANKS = 5'h0d;
  localparam logic [15:0] GPR_LIN_SIZE = 16'h0410;
  localparam logic [11:0] PCON_ADDR = 12'h00f;
  localparam logic [15:0] PTR_DATA_END = 16'h1000;
  localparam logic [15:0] PTR_LIN_BASE = 16'h2000;
  localparam int PTR_PM_BIT = 15;
  // Core register indices; byte address is four times the index.
  localparam logic [3:0] IDX_IND0 = 4'h0;
  localparam logic [3:0] IDX_IND1 = 4'h1;
  localparam logic [3:0] IDX_PC_LO = 4'h2;
  localparam logic [3:0] IDX_STATUS = 4'h3;
  localparam logic [3:0] IDX_P0_LO = 4'h4;
  localparam logic [3:0] IDX_P0_HI = 4'h5;
  localparam logic [3:0] IDX_P1_LO = 4'h6;
  localparam logic [3:0] IDX_P1_HI = 4'h7;
  localparam logic [3:0] IDX_BANK = 4'h8;
  localparam logic [3:0] IDX_ACC = 4'h9;
  localparam logic [3:0] IDX_PC_HI = 4'ha;
  localparam logic [3:0] IDX_IRQC = 4'hb;
  // Status and power control fields and reset values.
  localparam int ST_C = 0;
  localparam int ST_HC = 1;
  localparam int ST_Z = 2;
  localparam int ST_SLP = 3;
  localparam int ST_WDT = 4;
  localparam logic [4:0] STATUS_RST = 5'h18;
  localparam int PCON_OVF = 7;
  localparam int PCON_UNF = 6;
  localparam int PCON_RSTEN = 0;
  localparam logic PCON_RSTEN_RST = 1'b1;
  localparam int WB_DIRECT_BIT = 12;
  localparam int WB_HIGH_BIT = 13;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000, OP_STEP = 3'b001, OP_GOTO = 3'b010,
    OP_CALL = 3'b011, OP_RET = 3'b100, OP_IRQ = 3'b101,
    OP_RETFIE = 3'b110
  } cma_op_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00, BUS_PMWAIT = 2'b01, BUS_ACK = 2'b10
  } cma_bus_t;
  typedef enum logic [2:0] {
    LOC_NONE = 3'b000, LOC_CORE = 3'b001, LOC_PCON = 3'b010,
    LOC_GPR = 3'b011, LOC_COMMON = 3'b100, LOC_PM = 3'b101
  } cma_kind_t;
  typedef struct packed {cma_op_t op; logic [14:0] target;} cma_cmd_t;
  typedef struct packed {logic valid; logic z; logic hc; logic c;}
    cma_flags_t;
  typedef struct packed {cma_kind_t kind; logic [14:0] idx;} cma_loc_t;
  typedef struct packed {
    logic [14:0] pc;
    logic [15:0][14:0] stk;
    logic [4:0] sp;
    logic [4:0] status;
    logic [7:0] acc;
    logic [4:0] bank;
    logic [6:0] pc_hi;
    logic [7:0] irqc;
    logic [15:0] ptr0;
    logic [15:0] ptr1;
    logic [2:0] sh_status;
    logic [7:0] sh_acc;
    logic [4:0] sh_bank;
    logic [6:0] sh_pc_hi;
    logic [15:0] sh_ptr0;
    logic [15:0] sh_ptr1;
    logic ovf;
    logic unf;
    logic rsten;
    logic soft_rst;
    cma_bus_t bus;
    logic ack;
    logic [7:0] dat;
    logic [14:0] pm_addr;
  } cma_state_t;
endpackage

// File: dv/cpu_memory_addressing_core_tb.sv
// Self-checking bench for the CPU addressing core.
`timescale 1ns/1ns
module cpu_memory_addressing_core_tb;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [15:0] adr = 0;
  logic [31:0] wdat = 0, wb_dat_o;
  logic wb_ack_o, wdt = 0, slp = 0, clr = 0, soft_reset_o;
  logic [14:0] pc_o, pm_addr_o, pc_e;
  logic [13:0] pm_data_i;
  logic [7:0] q, v;
  cma_pkg::cma_cmd_t cmd_i = '0;
  cma_pkg::cma_flags_t flags_i = '0, fl = '0;
  int errors = 0, checked = 0, cycles = 0, lat, n;
  logic [14:0] rq[$];

  always #50 clk_i = ~clk_i;

  // The program store answers combinationally from the registered address.
  always_comb pm_data_i = pm_addr_o[13:0] * 14'h0003 + 14'h0007;

  cma_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
    .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cmd_i(cmd_i), .flags_i(flags_i), .wdt_timeout_i(wdt),
    .sleep_i(slp), .clrwdt_i(clr), .pc_o(pc_o), .pm_addr_o(pm_addr_o),
    .pm_data_i(pm_data_i), .soft_reset_o(soft_reset_o));

  // Prints the verdict and ends the run.
  task automatic summarize();
    if (errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // One classic cycle; data is taken at the very edge that sees ack.
  // Only the global cycle limit ends a wait for an answer.
  task automatic wb(input logic w, input logic [13:0] i, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= {i, 2'b00};
    wdat <= {24'h0, d};
    flags_i <= fl;
    lat = 0;
    do begin
      @(posedge clk_i);
      lat++;
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    cyc <= 0;
    stb <= 0;
    we <= 0;
    flags_i <= '0;
  endtask

  task automatic op(input cma_pkg::cma_op_t o, input logic [14:0] t);
    @(posedge clk_i);
    cmd_i <= '{o, t};
    @(posedge clk_i);
    cmd_i <= '{cma_pkg::OP_NONE, 15'h0};
    #1;
  endtask

  task automatic ev(input logic [2:0] e);
    @(posedge clk_i);
    {wdt, slp, clr} <= e;
    @(posedge clk_i);
    {wdt, slp, clr} <= 3'b000;
  endtask

  // Full data address of a linear GPR byte.
  function automatic logic [13:0] lin(input int k);
    return {2'b00, 5'(k / 80), 7'(8'h20 + k % 80)};
  endfunction

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
  end

  initial begin
    void'($urandom(93965));
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    #1;
    chk(pc_o, 15'h0000);
    wb(0, 14'h0003, 0);
    chk(q, 8'h18);
    wb(0, 14'h000f, 0);
    chk(q, 8'h01);
    // Random GPR bytes: full address, linear pointer, banked window.
    for (int k = 0; k < 10; k++) begin
      n = (k == 0) ? 1039 : $urandom % 1040;
      v = 8'($urandom);
      wb(1, lin(n), v);
      wb(1, 14'h0006, 8'(n));
      wb(1, 14'h0007, 8'(16'h2000 + n >> 8));
      wb(0, 14'h0001, 0);
      chk(q, v);
      chk(lat, 2);
      wb(1, 14'h0008, 8'(n / 80));
      wb(0, 14'h1000 | lin(n) & 14'h007f, 0);
      chk(q, v);
      wb(1, 14'h0007, 8'(lin(n) >> 8));
      wb(1, 14'h0006, 8'(lin(n)));
      wb(0, 14'h0001, 0);
      chk(q, v);
    end
    wb(1, 14'h0009, 8'h5a);
    wb(0, 14'h0489, 0);
    chk(q, 8'h5a);
    wb(1, 14'h0075, 8'h3c);
    wb(0, 14'h04f5, 0);
    chk(q, 8'h3c);
    wb(0, 14'h0a20, 0);
    chk(q, 8'h00);
    wb(0, 14'h0010, 0);
    chk(q, 8'h00);
    wb(0, 14'h2000, 0);
    chk(q, 8'h00);
    // Status masking and event flags.
    wb(1, 14'h0003, 8'he7);
    wb(0, 14'h0003, 0);
    chk(q, 8'h1f);
    fl = '{1'b1, 1'b1, 1'b0, 1'b1};
    wb(1, 14'h0003, 8'h00);
    fl = '0;
    wb(0, 14'h0003, 0);
    chk(q, 8'h1d);
    ev(3'b010);
    wb(0, 14'h0003, 0);
    chk(q & 8'h18, 8'h10);
    ev(3'b100);
    wb(0, 14'h0003, 0);
    chk(q & 8'h18, 8'h00);
    ev(3'b001);
    wb(0, 14'h0003, 0);
    chk(q & 8'h18, 8'h18);
    // Program word through a pointer, with wrap.
    wb(1, 14'h0004, 8'h56);
    wb(1, 14'h0005, 8'hb4);
    wb(0, 14'h0000, 0);
    chk(q, 8'(14'h1456 * 3 + 7));
    chk(lat, 3);
    chk(pm_addr_o, 15'h1456);
    wb(1, 14'h0000, 8'hee);
    wb(0, 14'h0000, 0);
    chk(q, 8'(14'h1456 * 3 + 7));
    // Program counter, wrap and PC_LOW_BYTE.
    op(cma_pkg::OP_GOTO, 15'h7abc);
    chk(pc_o, 15'h1abc);
    op(cma_pkg::OP_GOTO, 15'h1fff);
    op(cma_pkg::OP_STEP, 0);
    chk(pc_o, 15'h0000);
    wb(1, 14'h000a, 8'h3f);
    wb(1, 14'h0002, 8'h12);
    #1;
    chk(pc_o, 15'h1f12);
    // Shadow save and restore.
    op(cma_pkg::OP_GOTO, 15'h0123);
    op(cma_pkg::OP_IRQ, 0);
    chk(pc_o, 15'h0004);
    wb(1, 14'h0009, 8'ha5);
    op(cma_pkg::OP_RETFIE, 0);
    chk(pc_o, 15'h0123);
    wb(0, 14'h0009, 0);
    chk(q, 8'h5a);
    // A call followed at once by a return lands on the call site plus one.
    @(posedge clk_i);
    cmd_i <= '{cma_pkg::OP_CALL, 15'h0321};
    @(posedge clk_i);
    cmd_i <= '{cma_pkg::OP_RET, 15'h0};
    @(posedge clk_i);
    cmd_i <= '{cma_pkg::OP_NONE, 15'h0};
    #1;
    chk(pc_o, 15'h0124);
    // Stack depth, overflow without reset, then underflow with it.
    wb(1, 14'h000f, 8'h00);
    pc_e = 15'h0100;
    op(cma_pkg::OP_GOTO, pc_e);
    for (int k = 0; k < 17; k++) begin
      if (k < 16) rq.push_back(pc_e + 15'h1);
      pc_e = 15'h0200 + 15'($urandom % 256);
      op(cma_pkg::OP_CALL, pc_e);
      chk(pc_o, pc_e);
      chk(soft_reset_o, 1'b0);
    end
    wb(0, 14'h000f, 0);
    chk(q, 8'h80);
    for (int k = 0; k < 16; k++) begin
      op(cma_pkg::OP_RET, 0);
      chk(pc_o, rq.pop_back());
    end
    wb(1, 14'h000f, 8'h01);
    op(cma_pkg::OP_RET, 0);
    chk(soft_reset_o, 1'b1);
    chk(pc_o, 15'h0000);
    wb(0, 14'h000f, 0);
    chk(q & 8'h40, 8'h40);
    summarize();
  end
endmodule
